// File: core/tcp_bank.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
`include "tcp_params.svh"
// What this block does
// - Monitor-completed flag sets when the monitor condition holds during a monitoring run.
// - Monitor-completed flag clears when a new monitoring run begins.
// - Trigger monitor flag sets when the trace start bit establishes the trigger.
// - Trigger monitor flag clears when the sampling start bit launches a new trace.
// - Trace completed flag sets when the delay-selected number of samples after the trigger has been stored.
// - Trace completed flag clears on the next rising edge of sampling start.
// - Busy flag rises with sampling start, falls when the trace finishes.
// - Trace start rising edge sets the trigger; a signed delay picks valid samples.
// - Periodic sampling mode uses an interval of 10 to 2550 ms.
// - Instruction mode takes one sample per trace sample instruction.
// - Scan-end mode takes one sample at each program scan end.
// - Only the programming device drives sampling start; software cannot change it.
// - Start-up timestamp is rewritten in BCD on every power-on.
// - Start-up stamp: seconds, minutes in word one; hours, day in word two.
// - Power-loss timestamp is written in BCD at each power interruption.
// - Power-loss stamp uses the same seconds, minutes, hours, day layout.
// - Power-loss timestamp is kept through start-up and never cleared by power return.
module tcp_bank #(
   parameter int unsigned TICK_CYCLES = `TCP_BASE_MS * `TCP_CLK_KHZ
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire tcp_pkg::tcp_avm_req_t avs_req,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              prog_sample_start,
   input  wire logic              trace_sample_instruction,
   input  wire logic              scan_end,
   input  wire logic              diff_mon_start,
   input  wire logic              diff_mon_cond,
   input  wire logic              power_on,
   input  wire logic              power_fail,
   input  wire tcp_pkg::tcp_time_t cur_time,
   output logic                   sample_strobe,
   output logic [3:0]             sample_addr,
   output logic                   irq
);
   // ==========================================================
   // Bus slave
   logic        ack_q;
   logic        acc;
   logic [9:0]  idx;
   logic        wr_en;
   logic [31:0] rd_d;
   logic [31:0] readdata_q;

   assign acc             = avs_req.read | avs_req.write;
   assign idx             = avs_req.address[11:2];
   assign wr_en           = avs_req.write & ack_q;
   // One wait cycle: data is registered before the master samples it
   assign avs_waitrequest = acc & ~ack_q;
   assign avs_readdata    = readdata_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc & ~ack_q;
      end
   end

   // ==========================================================
   // Software-visible state
   logic [15:0]             ctrl;
   logic                    mon_done_q;
   logic                    mon_run_q;
   logic                    trig_q;
   logic                    done_q;
   logic                    busy_q;
   logic                    tstart_q;
   logic                    tstart_prev_q;
   logic                    sstart_prev_q;
   tcp_pkg::tcp_time_t      pon_ts_q;
   tcp_pkg::tcp_time_t      ploss_ts_q;
   logic [31:0]             cfg_q;
   logic [`TCP_IRQ_W-1:0]   irq_sts_q;
   logic [`TCP_IRQ_W-1:0]   irq_msk_q;
   logic [`TCP_IRQ_W-1:0]   irq_evt;

   always_comb begin
      ctrl                  = 16'h0000;
      ctrl[`TCP_B_MON_DONE] = mon_done_q;
      ctrl[`TCP_B_TRIG]     = trig_q;
      ctrl[`TCP_B_DONE]     = done_q;
      ctrl[`TCP_B_BUSY]     = busy_q;
      ctrl[`TCP_B_TSTART]   = tstart_q;
      ctrl[`TCP_B_SSTART]   = prog_sample_start;
   end

   always_comb begin
      unique case (idx)
         `TCP_IDX_CTRL:     rd_d = {16'h0000, ctrl};
         `TCP_IDX_PON_TS:   rd_d = pon_ts_q;
         `TCP_IDX_PLOSS_TS: rd_d = ploss_ts_q;
         `TCP_IDX_IRQ_STS:  rd_d = {{(32-`TCP_IRQ_W){1'b0}}, irq_sts_q};
         `TCP_IDX_IRQ_MSK:  rd_d = {{(32-`TCP_IRQ_W){1'b0}}, irq_msk_q};
         `TCP_IDX_CFG:      rd_d = cfg_q;
         default:           rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         readdata_q <= 32'h0000_0000;
      end else if (avs_req.read & ~ack_q) begin
         readdata_q <= rd_d;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= `TCP_CFG_RESET;
      end else if (wr_en && idx == `TCP_IDX_CFG) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_req.byteenable[b]) begin
               cfg_q[b*8 +: 8] <= avs_req.writedata[b*8 +: 8];
            end
         end
      end
   end

   // Trace start is software-owned; sampling start is not writable here
   always_ff @(posedge clk) begin
      if (reset || power_on) begin
         tstart_q <= 1'b0;
      end else if (wr_en && idx == `TCP_IDX_CTRL && avs_req.byteenable[1]) begin
         tstart_q <= avs_req.writedata[`TCP_B_TSTART];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tstart_prev_q <= 1'b0;
         sstart_prev_q <= 1'b0;
      end else begin
         tstart_prev_q <= tstart_q;
         sstart_prev_q <= prog_sample_start;
      end
   end

   // ==========================================================
   // Trace sequencer
   logic                 sstart_rise;
   logic                 tstart_rise;
   tcp_pkg::tcp_mode_t   mode;
   tcp_pkg::tcp_state_t  state_q;
   logic [7:0]           ivl_code;
   logic signed [7:0]    delay;
   logic signed [9:0]    post_raw;
   logic [4:0]           post_target;
   logic [4:0]           post_cnt_q;
   logic [31:0]          div_q;
   logic [7:0]           ivl_cnt_q;
   logic                 base_tick;
   logic                 periodic_hit;
   logic                 sample_evt;
   logic                 finish;

   assign sstart_rise = prog_sample_start & ~sstart_prev_q;
   assign tstart_rise = tstart_q & ~tstart_prev_q;
   assign mode        = tcp_pkg::tcp_mode_t'(cfg_q[`TCP_CFG_MODE_LO +: 2]);
   assign ivl_code    = cfg_q[`TCP_CFG_IVL_LO +: 8];
   assign delay       = cfg_q[`TCP_CFG_DLY_LO +: 8];
   // Positive delay keeps more samples after the trigger, negative fewer
   assign post_raw    = 10'(signed'({5'h00, `TCP_HALF})) + 10'(delay);
   always_comb begin
      if (post_raw < 10'sd1) begin
         post_target = 5'h01;
      end else if (post_raw > 10'(signed'({5'h00, `TCP_DEPTH}))) begin
         post_target = `TCP_DEPTH;
      end else begin
         post_target = post_raw[4:0];
      end
   end

   // 10 ms base tick, then interval code times the base (code 0 acts as 1)
   assign base_tick    = (div_q == 32'(TICK_CYCLES - 1));
   assign periodic_hit = base_tick && (ivl_cnt_q + 8'h01 >= ivl_code);

   always_ff @(posedge clk) begin
      if (reset || sstart_rise || state_q == tcp_pkg::TCP_ST_IDLE) begin
         div_q     <= 32'h0000_0000;
         ivl_cnt_q <= 8'h00;
      end else if (base_tick) begin
         div_q     <= 32'h0000_0000;
         ivl_cnt_q <= periodic_hit ? 8'h00 : ivl_cnt_q + 8'h01;
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   always_comb begin
      sample_evt = 1'b0;
      if (state_q == tcp_pkg::TCP_ST_SAMP && !sstart_rise) begin
         unique case (mode)
            tcp_pkg::TCP_MODE_PERIODIC: sample_evt = periodic_hit;
            tcp_pkg::TCP_MODE_INSTR:    sample_evt = trace_sample_instruction;
            tcp_pkg::TCP_MODE_SCAN_END: sample_evt = scan_end;
            default:                    sample_evt = scan_end;
         endcase
      end
   end

   assign finish = sample_evt && trig_q && (post_cnt_q + 5'h01 >= post_target);

   always_ff @(posedge clk) begin
      if (reset || power_on) begin
         state_q <= tcp_pkg::TCP_ST_IDLE;
         busy_q  <= 1'b0;
      end else if (sstart_rise) begin
         state_q <= tcp_pkg::TCP_ST_SAMP;
         busy_q  <= 1'b1;
      end else if (finish) begin
         state_q <= tcp_pkg::TCP_ST_IDLE;
         busy_q  <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || power_on) begin
         trig_q <= 1'b0;
      end else if (sstart_rise) begin
         trig_q <= 1'b0;
      end else if (tstart_rise && state_q == tcp_pkg::TCP_ST_SAMP) begin
         trig_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || power_on) begin
         done_q <= 1'b0;
      end else if (sstart_rise) begin
         done_q <= 1'b0;
      end else if (finish) begin
         done_q <= 1'b1;
      end
   end

   // Samples before the trigger keep wrapping over the region
   always_ff @(posedge clk) begin
      if (reset || sstart_rise) begin
         post_cnt_q    <= 5'h00;
         sample_addr   <= 4'h0;
         sample_strobe <= 1'b0;
      end else begin
         sample_strobe <= sample_evt;
         if (sample_evt) begin
            sample_addr <= sample_addr + 4'h1;
            if (trig_q) begin
               post_cnt_q <= post_cnt_q + 5'h01;
            end
         end
      end
   end

   // ==========================================================
   // Differentiate monitor
   always_ff @(posedge clk) begin
      if (reset || power_on) begin
         mon_run_q  <= 1'b0;
         mon_done_q <= 1'b0;
      end else if (diff_mon_start) begin
         mon_run_q  <= 1'b1;
         mon_done_q <= 1'b0;
      end else if (mon_run_q && diff_mon_cond) begin
         mon_run_q  <= 1'b0;
         mon_done_q <= 1'b1;
      end
   end

   // ==========================================================
   // Power timestamps
   always_ff @(posedge clk) begin
      if (reset) begin
         pon_ts_q <= '0;
      end else if (power_on) begin
         pon_ts_q <= cur_time;
      end
   end

   // Only a hard reset clears this; power return leaves it alone
   always_ff @(posedge clk) begin
      if (reset) begin
         ploss_ts_q <= '0;
      end else if (power_fail) begin
         ploss_ts_q <= cur_time;
      end
   end

   // ==========================================================
   // Interrupts
   always_comb begin
      irq_evt               = '0;
      irq_evt[`TCP_I_MON]   = mon_run_q & diff_mon_cond & ~diff_mon_start & ~power_on;
      irq_evt[`TCP_I_TRIG]  = tstart_rise & (state_q == tcp_pkg::TCP_ST_SAMP) & ~sstart_rise;
      irq_evt[`TCP_I_DONE]  = finish;
      irq_evt[`TCP_I_PON]   = power_on;
      irq_evt[`TCP_I_PLOSS] = power_fail;
   end

   // A new event wins over a write-one-to-clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_sts_q <= '0;
      end else if (wr_en && idx == `TCP_IDX_IRQ_STS && avs_req.byteenable[0]) begin
         irq_sts_q <= (irq_sts_q & ~avs_req.writedata[`TCP_IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_sts_q <= irq_sts_q | irq_evt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_msk_q <= '0;
      end else if (wr_en && idx == `TCP_IDX_IRQ_MSK && avs_req.byteenable[0]) begin
         irq_msk_q <= avs_req.writedata[`TCP_IRQ_W-1:0];
      end
   end

   assign irq = |(irq_sts_q & irq_msk_q);

   // ==========================================================
   // Checks
   a_mon_sets: assert property (@(posedge clk) disable iff (reset)
      mon_run_q && diff_mon_cond && !diff_mon_start && !power_on |=> mon_done_q)
      else $error("monitor flag not set on condition");
   a_mon_clears: assert property (@(posedge clk) disable iff (reset)
      diff_mon_start && !power_on |=> !mon_done_q && mon_run_q)
      else $error("monitor flag not cleared on new run");
   a_trig_sets: assert property (@(posedge clk) disable iff (reset)
      tstart_rise && busy_q && !sstart_rise && !power_on |=> trig_q)
      else $error("trigger flag not set");
   a_trig_clears: assert property (@(posedge clk) disable iff (reset)
      sstart_rise |=> !trig_q)
      else $error("trigger flag not cleared by new trace");
   a_done_sets: assert property (@(posedge clk) disable iff (reset)
      finish && !sstart_rise && !power_on |=> done_q && !busy_q)
      else $error("trace completion not flagged");
   a_done_clears: assert property (@(posedge clk) disable iff (reset)
      $rose(prog_sample_start) |=> !done_q)
      else $error("completed flag not cleared");
   a_busy_rise: assert property (@(posedge clk) disable iff (reset)
      $rose(prog_sample_start) && !power_on |=> busy_q)
      else $error("busy not raised");
   a_sample_addr: assert property (@(posedge clk) disable iff (reset)
      sample_evt && !sstart_rise |=> sample_strobe && sample_addr == $past(sample_addr) + 4'h1)
      else $error("sample not stored");
   a_ctrl_ro: assert property (@(posedge clk) disable iff (reset)
      ctrl[`TCP_B_SSTART] == prog_sample_start)
      else $error("sampling start bit not from programming device");
   a_pon_stamp: assert property (@(posedge clk) disable iff (reset)
      power_on |=> pon_ts_q == $past(cur_time))
      else $error("start-up time not stored");
   a_ploss_keep: assert property (@(posedge clk) disable iff (reset)
      power_on && !power_fail |=> $stable(ploss_ts_q))
      else $error("power-loss time disturbed at start-up");
   a_flags_pon: assert property (@(posedge clk) disable iff (reset)
      power_on |=> !trig_q && !done_q && !busy_q && !mon_done_q)
      else $error("flags not cleared at power-up");

   c_trace_done: cover property (@(posedge clk) disable iff (reset) finish);
   c_mon_done: cover property (@(posedge clk) disable iff (reset) $rose(mon_done_q));
   c_irq: cover property (@(posedge clk) disable iff (reset) $rose(irq));
endmodule : tcp_bank

// File: core/tcp_params.svh
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH
// Register indices; byte address is four times the index
`define TCP_IDX_CTRL     10'h1fc
`define TCP_IDX_PON_TS   10'h1fe
`define TCP_IDX_PLOSS_TS 10'h200
`define TCP_IDX_IRQ_STS  10'h202
`define TCP_IDX_IRQ_MSK  10'h203
`define TCP_IDX_CFG      10'h204
// Control word bit positions
`define TCP_B_MON_DONE   9
`define TCP_B_TRIG       11
`define TCP_B_DONE       12
`define TCP_B_BUSY       13
`define TCP_B_TSTART     14
`define TCP_B_SSTART     15
// Interrupt status bit positions
`define TCP_I_MON        0
`define TCP_I_TRIG       1
`define TCP_I_DONE       2
`define TCP_I_PON        3
`define TCP_I_PLOSS      4
`define TCP_IRQ_W        5
// Configuration field layout and reset
`define TCP_CFG_MODE_LO  0
`define TCP_CFG_IVL_LO   8
`define TCP_CFG_DLY_LO   16
`define TCP_CFG_RESET    32'h0000_0100
// Timing
`define TCP_CLK_KHZ      20000
`define TCP_BASE_MS      10
// Trace region
`define TCP_DEPTH        5'h10
`define TCP_HALF         5'h08
`endif

// File: core/tcp_pkg.sv
package tcp_pkg;
   typedef enum logic [1:0] {
      TCP_MODE_PERIODIC = 2'b00,
      TCP_MODE_INSTR    = 2'b01,
      TCP_MODE_SCAN_END = 2'b10
   } tcp_mode_t;

   typedef enum logic [0:0] {
      TCP_ST_IDLE = 1'b0,
      TCP_ST_SAMP = 1'b1
   } tcp_state_t;

   // BCD time, second word in the upper half
   typedef struct packed {
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } tcp_time_t;

   typedef struct packed {
      logic [11:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } tcp_avm_req_t;
endpackage : tcp_pkg

// File: verification/tcp_prog_dev.sv
`timescale 1ns/1ns
// =====================================================
// Programming device: the only source of sampling start
module tcp_prog_dev (
   input  wire logic clk,
   input  wire logic run,
   output logic      sample_start
);
   initial sample_start = 1'b0;
   // Registered copy of the operator request, so every start is a clean 0-to-1 step
   always @(posedge clk) begin
      sample_start <= run;
   end
endmodule : tcp_prog_dev

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam logic [11:0] A_CTRL = 12'h7f0;
   localparam logic [11:0] A_PON  = 12'h7f8;
   localparam logic [11:0] A_LOSS = 12'h800;
   localparam logic [11:0] A_STS  = 12'h808;
   localparam logic [11:0] A_MSK  = 12'h80c;
   localparam logic [11:0] A_CFG  = 12'h810;
   localparam logic [11:0] A_NONE = 12'h7f4;
   localparam logic [4:0]  E_INSTR = 5'h01;
   localparam logic [4:0]  E_SCAN  = 5'h02;
   localparam logic [4:0]  E_MON   = 5'h04;
   localparam logic [4:0]  E_PON   = 5'h08;
   localparam logic [4:0]  E_FAIL  = 5'h10;
   logic                  clk    = 1'b0;
   logic                  reset  = 1'b1;
   tcp_pkg::tcp_avm_req_t req    = '0;
   tcp_pkg::tcp_time_t    now    = '0;
   logic                  run    = 1'b0;
   // Event pulses: instruction, scan end, monitor start, power on, power fail
   logic [4:0]            ev     = 5'h00;
   logic                  mcond  = 1'b0;
   logic [31:0]           rdata;
   logic [31:0]           got;
   logic [3:0]            saddr;
   logic                  wait_req;
   logic                  sstart;
   logic                  strobe;
   logic                  irq;
   int                    n_fail      = 0;
   int                    comparisons = 0;
   int                    strobes     = 0;
   int                    cycles      = 0;
   int                    s0          = 0;

   always #25 clk = ~clk;

   tcp_prog_dev prog_u (.clk(clk), .run(run), .sample_start(sstart));

   tcp_bank #(.TICK_CYCLES(4)) dut_u (
      .clk(clk), .reset(reset), .avs_req(req), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .prog_sample_start(sstart),
      .trace_sample_instruction(ev[0]), .scan_end(ev[1]), .diff_mon_start(ev[2]),
      .diff_mon_cond(mcond), .power_on(ev[3]), .power_fail(ev[4]), .cur_time(now),
      .sample_strobe(strobe), .sample_addr(saddr), .irq(irq)
   );

   // =====================================================
   // Reporting
   task automatic final_report;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Strobe count at the falling edge, where the registered pulse has settled
   always @(negedge clk) begin
      if (strobe === 1'b1) begin
         strobes++;
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         final_report();
      end
   end

   // =====================================================
   // Avalon master; entered just after a rising edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      req.address <= a;
      req.write <= wr;
      req.read <= !wr;
      req.writedata <= d;
      req.byteenable <= 4'hf;
      // No limit here: the hang guard ends a wait that never finishes
      do begin
         @(posedge clk);
      end while (wait_req !== 1'b0);
      got = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      // Idle edge keeps strobes from being driven twice in one step
      @(posedge clk);
   endtask : bus

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, '0);
      chk(got, e);
   endtask : rd_chk

   task automatic pulse(input logic [4:0] m, input int k);
      repeat (k) begin
         ev <= m;
         @(posedge clk);
         ev <= 5'h00;
         repeat (2) @(posedge clk);
      end
   endtask : pulse

   // =====================================================
   // Sequence
   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd_chk(A_CTRL, 32'h0000_0000);
      rd_chk(A_CFG, 32'h0000_0100);
      rd_chk(A_NONE, 32'h0000_0000);
      // Instruction mode, zero delay: eight samples after the trigger
      bus(1'b1, A_CFG, 32'h0000_0001);
      run <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(A_CTRL, 32'h0000_a000);
      bus(1'b1, A_CTRL, 32'h0000_4000);
      rd_chk(A_CTRL, 32'h0000_e800);
      pulse(E_INSTR, 8);
      rd_chk(A_CTRL, 32'h0000_d800);
      chk(32'(strobes), 32'h8);
      chk({28'h0, saddr}, 32'h8);
      // Software may not drive the sampling start bit
      run <= 1'b0;
      repeat (3) @(posedge clk);
      bus(1'b1, A_CTRL, 32'h0000_8000);
      rd_chk(A_CTRL, 32'h0000_1800);
      // Scan-end mode, delay -7 leaves one sample after the trigger
      bus(1'b1, A_CFG, 32'h00f9_0002);
      run <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(A_CTRL, 32'h0000_a000);
      bus(1'b1, A_CTRL, 32'h0000_4000);
      pulse(E_SCAN, 1);
      rd_chk(A_CTRL, 32'h0000_d800);
      chk(32'(strobes), 32'h9);
      // Periodic mode, 20 ms interval: one sample every 8 clocks here
      run <= 1'b0;
      bus(1'b1, A_CFG, 32'h00f9_0200);
      run <= 1'b1;
      bus(1'b1, A_CTRL, 32'h0000_0000);
      s0 = strobes;
      repeat (32) @(posedge clk);
      chk(32'(strobes - s0), 32'h4);
      bus(1'b1, A_CTRL, 32'h0000_4000);
      repeat (30) @(posedge clk);
      rd_chk(A_CTRL, 32'h0000_d800);
      // Differentiate monitoring
      pulse(E_MON, 1);
      rd_chk(A_CTRL, 32'h0000_d800);
      mcond <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(A_CTRL, 32'h0000_da00);
      mcond <= 1'b0;
      pulse(E_MON, 1);
      rd_chk(A_CTRL, 32'h0000_d800);
      // Power events and timestamps
      now <= 32'h1509_3045;
      pulse(E_PON, 1);
      rd_chk(A_PON, 32'h1509_3045);
      rd_chk(A_CTRL, 32'h0000_8000);
      rd_chk(A_LOSS, 32'h0000_0000);
      now <= 32'h3123_5959;
      pulse(E_FAIL, 1);
      rd_chk(A_LOSS, 32'h3123_5959);
      now <= 32'h0100_0001;
      pulse(E_PON, 1);
      rd_chk(A_PON, 32'h0100_0001);
      rd_chk(A_LOSS, 32'h3123_5959);
      bus(1'b1, A_PON, 32'h0000_0000);
      bus(1'b1, A_NONE, 32'hffff_ffff);
      rd_chk(A_PON, 32'h0100_0001);
      rd_chk(A_NONE, 32'h0000_0000);
      // Interrupt: every event latched, masked, unmasked, cleared
      chk({31'h0, irq}, 32'h0);
      rd_chk(A_STS, 32'h0000_001f);
      bus(1'b1, A_MSK, 32'h0000_0008);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, A_STS, 32'h0000_001f);
      chk({31'h0, irq}, 32'h0);
      rd_chk(A_STS, 32'h0000_0000);
      final_report();
   end
endmodule : testbench
